// [src/tsc_buf2.v]
// Two-entry valid/ready buffer for received bytes.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tsc_buf2 #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clock,
  input  wire         rst_n,
  // Fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // Drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_reg [0:1];   // Storage
  reg         wr_ptr_reg;      // Write slot
  reg         rd_ptr_reg;      // Read slot
  reg [1:0]   cnt_reg;         // Occupancy
  wire        push;
  wire        pop;

  assign in_ready  = (cnt_reg != 2'd2);
  assign out_valid = (cnt_reg != 2'd0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count upkeep
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'd0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      if (push & ~pop) cnt_reg <= cnt_reg + 2'd1;
      else if (pop & ~push) cnt_reg <= cnt_reg - 2'd1;
    end
  end

  // Data storage, no reset needed
  always @(posedge clock) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end
endmodule
`default_nettype wire

// [src/tsc_codec.v]
// Timer / shift register line codec: modulators and demodulators
// built from timer 2, timer 3 and an 8-bit shift register.
// Assumes configuration inputs held steady while enable is high.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.vh"
module tsc_codec #(
  parameter SR_W  = `TSC_SR_W,
  parameter PRE_W = `TSC_PRE_W
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst_n,
  // Configuration
  input  wire             enable,
  input  wire [3:0]       mode,
  input  wire [PRE_W-1:0] t2_prescale,
  input  wire [7:0]       t2_compare,
  input  wire [7:0]       t3_compare1,
  input  wire [7:0]       t3_compare2,
  input  wire             use_ext_clock,
  input  wire             output_mask_en,
  input  wire [PRE_W-1:0] telegram_bits,
  // Transmit byte
  input  wire             tx_valid,
  output reg              tx_ready,
  input  wire [SR_W-1:0]  tx_data,
  // Received byte
  output wire             rx_valid,
  input  wire             rx_ready,
  output wire [SR_W-1:0]  rx_data,
  // Line pins
  input  wire             timer3_line_input,
  input  wire             ext_clock_in,
  output reg              timer3_line_output,
  // Status
  output reg              timer2_toggle_out,
  output reg              output_mask_stop,
  output reg              timing_error
);
  // Input synchronisers
  reg [1:0] lin_sync_reg;       // Line input, two flops
  reg [1:0] ext_sync_reg;       // External clock, two flops
  reg       lin_d_reg;          // Previous synced line level
  reg       ext_d_reg;          // Previous synced ext clock
  wire      lin;
  wire      lin_rise;
  wire      lin_edge;
  wire      ext_tick;

  // Timer 2
  reg [PRE_W-1:0] t2_pre_reg;   // Prescaler
  reg [7:0]       t2_cnt_reg;   // Compare counter
  reg             t2_tick;      // Compare match pulse

  // Timer 3
  reg [7:0]       t3_cnt_reg;   // Counter
  reg             t3_restart;   // Restart request
  wire            t3_clk_en;
  wire [7:0]      t3_cmp_sel;

  // Shift register and transmit side
  reg [SR_W-1:0]  sr_reg;       // Shift register
  reg [3:0]       bit_cnt_reg;  // Bits left to send; bits taken when decoding
  reg             sr_full_reg;  // Holds a byte to send
  reg             phase_reg;    // Half-bit phase for coding
  reg [PRE_W-1:0] tel_cnt_reg;  // Telegram bit counter
  reg             carrier_reg;  // Timer 3 carrier toggle
  wire            so;
  wire            is_demod;

  // Demodulator
  reg             armed_reg;    // Waiting for compare 1
  reg             biph_tff_reg; // Mid-bit toggle flop
  reg             rx_push;
  wire            rx_in_ready;

  assign lin      = lin_sync_reg[1];
  assign lin_rise = lin & ~lin_d_reg;
  assign lin_edge = lin ^ lin_d_reg;
  assign ext_tick = ext_sync_reg[1] & ~ext_d_reg;
  assign so       = sr_reg[SR_W-1];
  assign is_demod = (mode == `TSC_MODE_DMANCH) | (mode == `TSC_MODE_DPWM) |
                    (mode == `TSC_MODE_DBIPH);
  // Demodulation ignores the external clock
  assign t3_clk_en = (use_ext_clock & ~is_demod) ? ext_tick : 1'b1;
  // Data bit picks compare register
  assign t3_cmp_sel = so ? t3_compare2 : t3_compare1;

  // Synchronise pins
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lin_sync_reg <= 2'b00;
      ext_sync_reg <= 2'b00;
      lin_d_reg    <= 1'b0;
      ext_d_reg    <= 1'b0;
    end else begin
      lin_sync_reg <= {lin_sync_reg[0], timer3_line_input};
      ext_sync_reg <= {ext_sync_reg[0], ext_clock_in};
      lin_d_reg    <= lin_sync_reg[1];
      ext_d_reg    <= ext_sync_reg[1];
    end
  end

  // Timer 2: prescaler then 8-bit compare counter
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      t2_pre_reg        <= {PRE_W{1'b0}};
      t2_cnt_reg        <= 8'h00;
      t2_tick           <= 1'b0;
      timer2_toggle_out <= 1'b0;
    end else begin
      t2_tick <= 1'b0;
      if (!enable) begin
        t2_pre_reg <= {PRE_W{1'b0}};
        t2_cnt_reg <= 8'h00;
      end else if (t2_pre_reg >= t2_prescale) begin
        t2_pre_reg <= {PRE_W{1'b0}};
        if (t2_cnt_reg >= t2_compare) begin
          t2_cnt_reg        <= 8'h00;
          t2_tick           <= 1'b1;
          timer2_toggle_out <= ~timer2_toggle_out;
        end else begin
          t2_cnt_reg <= t2_cnt_reg + 8'h01;
        end
      end else begin
        t2_pre_reg <= t2_pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Timer 3 counter and carrier, restart on request
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      t3_cnt_reg  <= 8'h00;
      carrier_reg <= 1'b0;
    end else if (!enable || t3_restart) begin
      t3_cnt_reg  <= 8'h00;
      carrier_reg <= 1'b0;
    end else if (t3_clk_en) begin
      if (!is_demod && t3_cnt_reg >= t3_cmp_sel) begin
        t3_cnt_reg  <= 8'h00;
        carrier_reg <= ~carrier_reg;
      end else if (t3_cnt_reg != 8'hFF) begin
        t3_cnt_reg <= t3_cnt_reg + 8'h01;
      end
    end
  end

  // Restart sources for timer 3
  always @* begin
    t3_restart = 1'b0;
    case (mode)
      `TSC_MODE_PWM:    t3_restart = t2_tick;
      `TSC_MODE_DMANCH: t3_restart = lin_edge & ~armed_reg;
      `TSC_MODE_DBIPH:  t3_restart = lin_edge & ~armed_reg;
      `TSC_MODE_DPWM:   t3_restart = lin_rise;
      default:          t3_restart = 1'b0;
    endcase
  end

  // Shift register: transmit on timer 2 toggle, receive on compare 1
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sr_reg           <= `TSC_SR_RST;
      bit_cnt_reg      <= 4'd0;
      sr_full_reg      <= 1'b0;
      tx_ready         <= 1'b0;
      phase_reg        <= 1'b0;
      tel_cnt_reg      <= {PRE_W{1'b0}};
      output_mask_stop <= 1'b0;
      armed_reg        <= 1'b0;
      biph_tff_reg     <= 1'b0;
      rx_push          <= 1'b0;
      timing_error     <= 1'b0;
    end else begin
      rx_push      <= 1'b0;
      timing_error <= 1'b0;
      tx_ready     <= enable & ~is_demod & ~sr_full_reg;
      if (!enable) begin
        sr_full_reg      <= 1'b0;
        bit_cnt_reg      <= 4'd0;
        phase_reg        <= 1'b0;
        armed_reg        <= 1'b0;
        tel_cnt_reg      <= {PRE_W{1'b0}};
        output_mask_stop <= 1'b0;
      end else if (!is_demod) begin
        if (tx_ready && tx_valid && !sr_full_reg) begin
          sr_reg      <= tx_data;
          sr_full_reg <= 1'b1;
          bit_cnt_reg <= SR_W[3:0];
          tx_ready    <= 1'b0;
        end else if (sr_full_reg && t2_tick && !output_mask_stop) begin
          // Each toggle is a half bit; shift on the second half
          phase_reg <= ~phase_reg;
          if (phase_reg) begin
            sr_reg      <= {sr_reg[SR_W-2:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg - 4'd1;
            if (bit_cnt_reg == 4'd1) sr_full_reg <= 1'b0;
            tel_cnt_reg <= tel_cnt_reg + {{(PRE_W-1){1'b0}}, 1'b1};
            if (output_mask_en && tel_cnt_reg + {{(PRE_W-1){1'b0}}, 1'b1} == telegram_bits)
              output_mask_stop <= 1'b1;
          end
        end
      end else begin
        // Demodulation: bit-mid toggle, compare 1 sample, compare 2 error
        if (lin_edge && armed_reg) biph_tff_reg <= ~biph_tff_reg;
        if (t3_restart) armed_reg <= 1'b1;
        if (armed_reg && t3_cnt_reg == t3_compare1 && t3_clk_en) begin
          sr_reg <= {sr_reg[SR_W-2:0],
                     (mode == `TSC_MODE_DBIPH) ? biph_tff_reg : lin};
          armed_reg    <= (mode == `TSC_MODE_DPWM);
          biph_tff_reg <= 1'b0;
          if (bit_cnt_reg == SR_W[3:0] - 4'd1) begin
            bit_cnt_reg <= 4'd0;
            rx_push     <= rx_in_ready;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end
        end
        if (t3_cnt_reg == t3_compare2 && t3_clk_en) timing_error <= 1'b1;
      end
    end
  end

  // Line output encoder
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer3_line_output <= `TSC_LINE_RST;
    end else if (!enable || output_mask_stop || !sr_full_reg) begin
      timer3_line_output <= `TSC_LINE_RST;
    end else begin
      case (mode)
        `TSC_MODE_BURST: timer3_line_output <= so & carrier_reg;
        `TSC_MODE_BIPH:  timer3_line_output <= ~(phase_reg & ~so);
        `TSC_MODE_MANCH: timer3_line_output <= so ^ phase_reg;
        `TSC_MODE_FSK:   timer3_line_output <= carrier_reg;
        `TSC_MODE_PWM:   timer3_line_output <= (t3_cnt_reg < t3_cmp_sel);
        default:         timer3_line_output <= `TSC_LINE_RST;
      endcase
    end
  end

  // Received bytes buffered two deep; a byte done while both entries are full is dropped
  tsc_buf2 #(.W(SR_W)) u_rxbuf (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (sr_reg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );
endmodule
`default_nettype wire

// [src/tsc_regs.vh]
// Constants for the timer / shift register line codec.
// Assumes inclusion by bare name from src/ design files.
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
// Combination mode codes
`define TSC_MODE_BURST   4'h1
`define TSC_MODE_BIPH    4'h2
`define TSC_MODE_MANCH   4'h3
`define TSC_MODE_FSK     4'h6
`define TSC_MODE_PWM     4'h7
`define TSC_MODE_DMANCH  4'h8
`define TSC_MODE_DPWM    4'h9
`define TSC_MODE_DBIPH   4'hA
// Widths
`define TSC_SR_W         8
`define TSC_PRE_W        4
// Reset values
`define TSC_SR_RST       8'h00
`define TSC_LINE_RST     1'b0
`endif

// [tb/tb_top.sv]
// Self-checking bench for the line codec.
// Assumes codec, checker and line model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.vh"
module tb_top;
  typedef struct packed {logic [3:0] m; logic [7:0] a, b, d;} tsc_row_t;
  logic        clock, rst_n, enable, use_ext_clock, ext_clock_in, output_mask_en;
  logic        tx_valid, rx_ready, go;
  logic [3:0]  mode, t2p, telegram_bits;
  logic [7:0]  t2c, c1, c2, tx_data, got;
  logic [23:0] word;
  wire         tx_ready, rx_valid, line_out, tog, mstop, terr, line_in;
  wire  [7:0]  rx_data;
  int          errors, num_checks, k, t, n;
  // Mode, compare 1, compare 2, byte sent and expected back
  // Compare values stay clear of extreme duty cycles
  tsc_row_t    rows [7] = '{
    '{`TSC_MODE_BURST, 8'h01, 8'h01, 8'h00}, '{`TSC_MODE_BURST, 8'h01, 8'h01, 8'hFF},
    '{`TSC_MODE_BURST, 8'h01, 8'h01, 8'h80}, '{`TSC_MODE_BURST, 8'h01, 8'h01, 8'h01},
    '{`TSC_MODE_BURST, 8'h01, 8'h01, 8'hA5}, '{`TSC_MODE_FSK, 8'h01, 8'h07, 8'h5A},
    '{`TSC_MODE_FSK, 8'h01, 8'h07, 8'h0F}};
  tsc_codec i_dut (
    .clock(clock), .rst_n(rst_n), .enable(enable), .mode(mode),
    .t2_prescale(t2p), .t2_compare(t2c), .t3_compare1(c1), .t3_compare2(c2),
    .use_ext_clock(use_ext_clock), .ext_clock_in(ext_clock_in),
    .output_mask_en(output_mask_en), .telegram_bits(telegram_bits),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .timer3_line_input(line_in),
    .timer3_line_output(line_out), .timer2_toggle_out(tog),
    .output_mask_stop(mstop), .timing_error(terr));
  tsc_line_src i_src (.clock(clock), .go(go), .word(word), .nbits(5'd24), .line(line_in));
  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Verdict, the single exit
  task report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  // Bounded waits end the run when exhausted
  task hung(input int c, input int lim);
    if (c >= lim) begin
      errors++;
      $display("BAD wait exp done got timeout");
      report_and_stop();
    end
  endtask
  // Mode and compare values only change with the codec stopped
  task cfg(input logic [3:0] m, input logic [7:0] a, input logic [7:0] b);
    enable = 1'b0;
    repeat (3) @(negedge clock);
    mode = m;
    c1 = a;
    c2 = b;
    @(negedge clock);
    enable = 1'b1;
  endtask
  // Cycles until the timer 2 toggle next changes
  task wait_tog;
    logic p;
    p = tog;
    for (n = 0; tog === p; n++) begin
      hung(n, 400);
      @(negedge clock);
    end
  endtask
  // Send a byte; count line changes in each second half-bit only,
  // which is right whether output lags the tick by a half or not
  task tx_byte(input logic [7:0] d, input logic fsk);
    logic pt, pl;
    int   j, cnt [8];
    for (t = 0; tx_ready !== 1'b1; t++) begin
      hung(t, 300);
      @(negedge clock);
    end
    tx_valid = 1'b1;
    tx_data = d;
    @(negedge clock);
    tx_valid = 1'b0;
    pt = tog;
    pl = line_out;
    cnt = '{default: 0};
    for (n = 0, t = 0; n < 16; t++) begin
      hung(t, 600);
      @(negedge clock);
      if (n % 2 == 1 && line_out !== pl) cnt[n / 2]++;
      if (tog !== pt) n++;
      pt = tog;
      pl = line_out;
    end
    for (j = 0; j < 8; j++) got[7 - j] = fsk ? (cnt[j] < 5) : (cnt[j] > 0);
  endtask
  initial begin
    {enable, tx_valid, rx_ready, go, use_ext_clock, ext_clock_in, output_mask_en} = '0;
    {mode, t2p, telegram_bits, t2c, c1, c2, tx_data, word} = '0;
    rst_n = 1'b0;
    repeat (10) @(negedge clock);
    chk("reset outs", 8'h00, {2'b00, tx_ready, rx_valid, line_out, tog, mstop, terr});
    rst_n = 1'b1;
    // Tick period against prescaler and compare
    for (k = 0; k < 2; k++) begin
      t2p = k ? 4'h0 : 4'h2;
      t2c = k ? 8'h0F : 8'h04;
      cfg(`TSC_MODE_BURST, 8'h01, 8'h01);
      wait_tog();
      wait_tog();
      chk("t2 period", (t2p + 1) * (t2c + 1), n[7:0]);
    end
    for (k = 0; k < 7; k++) begin
      cfg(rows[k].m, rows[k].a, rows[k].b);
      tx_byte(rows[k].d, rows[k].m == `TSC_MODE_FSK);
      chk("line byte", rows[k].d, got);
    end
    // Three bytes into a stalled two-entry buffer
    cfg(`TSC_MODE_DMANCH, 8'h18, 8'h28);
    word = 24'h3C_A596;
    go = 1'b1;
    for (t = 0; terr !== 1'b1; t++) begin
      hung(t, 1500);
      @(negedge clock);
    end
    chk("late error", 8'h01, {7'h00, t > 780});
    for (k = 0; k < 2; k++) begin
      chk("rx valid", 8'h01, {7'h00, rx_valid});
      chk("rx byte", k ? 8'hA5 : 8'h3C, rx_data);
      rx_ready = 1'b1;
      @(negedge clock);
      rx_ready = 1'b0;
    end
    chk("rx dropped", 8'h00, {7'h00, rx_valid});
    report_and_stop();
  end
endmodule
`default_nettype wire

// [tb/tsc_codec_chk.sv]
// Checker for the line codec: handshakes, status pulses, timer quiet.
// Assumes it is bound to tsc_codec and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.vh"
module tsc_codec_chk #(
  parameter SR_W = 8
) (
  // Clock and reset
  input wire logic            clock,
  input wire logic            rst_n,
  // Watched ports
  input wire logic            enable,
  input wire logic [3:0]      mode,
  input wire logic            tx_valid,
  input wire logic            tx_ready,
  input wire logic            rx_valid,
  input wire logic            rx_ready,
  input wire logic [SR_W-1:0] rx_data,
  input wire logic            timer2_toggle_out,
  input wire logic            timing_error
);
  // Decode modes, the only ones that may flag a timing error
  wire dec = (mode == `TSC_MODE_DMANCH) || (mode == `TSC_MODE_DPWM) || (mode == `TSC_MODE_DBIPH);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Byte accepted by the shifter
  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  a_take_drop: assert property (s_take |=> !tx_ready)
    else $error("tx_ready still high after take");
  // A byte needs 16 ticks of at least one cycle, so 8 is safe
  a_busy_hold: assert property (disable iff (!rst_n || !enable) s_take |=> !tx_ready [*8])
    else $error("tx_ready back too early");
  a_ready_stands: assert property (tx_ready && !tx_valid && enable |=> tx_ready || !enable)
    else $error("tx_ready dropped untaken");
  a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
    else $error("rx word lost while stalled");
  a_err_decode: assert property (timing_error |-> $past(dec))
    else $error("timing error outside decode");
  a_err_pulse: assert property (timing_error |=> !timing_error)
    else $error("timing error longer than a pulse");
  // Stopped timer must not tick
  a_tog_quiet: assert property (!enable && !$past(enable) && !$past(enable, 2)
    |-> $stable(timer2_toggle_out))
    else $error("timer 2 ticks while stopped");
  a_reset_idle: assert property ($rose(rst_n) |-> !tx_ready && !rx_valid && !timing_error)
    else $error("outputs busy after reset");
endmodule
bind tsc_codec tsc_codec_chk #(.SR_W(SR_W)) i_chk (
  .clock(clock), .rst_n(rst_n), .enable(enable), .mode(mode),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_data(rx_data),
  .timer2_toggle_out(timer2_toggle_out), .timing_error(timing_error));
`default_nettype wire

// [tb/tsc_line_src.sv]
// Far-side line transmitter: sends a sync bit then Manchester data.
// Assumes the codec samples its line pin on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tsc_line_src #(
  parameter HALF = 16
) (
  // Clock
  input  wire logic        clock,
  // Frame request
  input  wire logic        go,
  input  wire logic [23:0] word,
  input  wire logic [4:0]  nbits,
  // Line pin
  output var  logic        line
);
  int i;
  // Idle high matches the sync bit's first half, so the first edge
  // seen is mid-bit and the decoder locks on a full bit interval
  initial begin
    line = 1'b1;
    forever begin
      @(posedge go);
      for (i = -1; i < int'(nbits); i++) begin
        line <= (i < 0) ? 1'b1 : word[int'(nbits) - 1 - i];
        repeat (HALF) @(posedge clock);
        line <= (i < 0) ? 1'b0 : ~word[int'(nbits) - 1 - i];
        repeat (HALF) @(posedge clock);
      end
    end
  end
endmodule
`default_nettype wire
